// *** inc/icp_pkg.sv ***
package icp_pkg;
    // system clock and bus rates
    localparam int CLK_HZ = 10_000_000;
    localparam int STD_HZ = 100_000;
    localparam int FAST_HZ = 400_000;
    // quarter bit periods in system clocks, rounded up so the bus never runs fast
    localparam int QTR_STD = (CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ);
    localparam int QTR_FAST = (CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);

    // target address and register map
    localparam logic [4:0] ADDR_UPPER = 5'h18;
    localparam logic [15:0] COMMIT_ADDR = 16'h0234;
    localparam int COMMIT_BIT = 0;
    localparam int REG_COUNT = 8;
    localparam int IDX_W = 3;
    localparam logic [7:0] READ_FILL = 8'h00;
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] STRAP_FOUR_WIRE = 2'h0;

    typedef enum logic [2:0] {T_IDLE, T_RX, T_ACK, T_TX, T_RACK} icp_tst_t;
    typedef enum logic [1:0] {PH_DEV, PH_AHI, PH_ALO, PH_DATA} icp_phase_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} icp_hst_t;
    typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} icp_op_t;
    typedef logic [REG_COUNT*8-1:0] icp_regs_t;

    function automatic logic reg_hit(input logic [15:0] a);
        return a < 16'(REG_COUNT);
    endfunction

    function automatic logic [IDX_W-1:0] reg_idx(input logic [15:0] a);
        return a[IDX_W-1:0];
    endfunction
endpackage

// *** inc/icp_if.sv ***
`timescale 1ns/10ps
interface icp_if (
    input logic link_clk
);
    logic scl_out;
    logic scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // open-drain wires with pull-up
    assign scl = scl_oe_n | scl_out;
    assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

    modport ctrl (
        output scl_out,
        output scl_oe_n,
        output host_sda_out,
        output host_sda_oe_n,
        input sda
    );
    modport tgt (
        input link_clk,
        input scl,
        input sda,
        output dev_sda_out,
        output dev_sda_oe_n
    );
endinterface

// *** rtl/icp_regbank.sv ***
`timescale 1ns/10ps
module icp_regbank (
    // link domain
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] rd_addr,
    output logic [7:0] rd_data,
    // system domain
    input wire logic clock,
    input wire logic sys_rst,
    output icp_pkg::icp_regs_t active_regs,
    output logic commit_pulse
);
    typedef struct packed {
        icp_pkg::icp_regs_t staged;
        icp_pkg::icp_regs_t active;
        logic tog;
    } icp_bank_t;

    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        icp_pkg::icp_regs_t regs;
        logic pulse;
    } icp_sys_t;

    icp_bank_t ln_q;
    icp_bank_t ln_d;
    icp_sys_t sy_q;
    icp_sys_t sy_d;

    always_comb begin
        ln_d = ln_q;
        if (link_rst) begin
            ln_d.staged = {icp_pkg::REG_COUNT{icp_pkg::STAGE_RESET}};
            ln_d.active = {icp_pkg::REG_COUNT{icp_pkg::STAGE_RESET}};
            ln_d.tog = 1'b0;
        end else if (wr_en) begin
            if (icp_pkg::reg_hit(wr_addr)) begin
                ln_d.staged[icp_pkg::reg_idx(wr_addr)*8 +: 8] = wr_data; // see R21
            end
            // commit bit is not stored, so it reads back as zero
            if (wr_addr == icp_pkg::COMMIT_ADDR && wr_data[icp_pkg::COMMIT_BIT]) begin
                ln_d.active = ln_q.staged; // see R21
                ln_d.tog = ~ln_q.tog;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        ln_q <= ln_d;
    end

    assign rd_data = icp_pkg::reg_hit(rd_addr) ?
        ln_q.staged[icp_pkg::reg_idx(rd_addr)*8 +: 8] : icp_pkg::READ_FILL;

    // active copy is stable for two system clocks before the toggle is seen
    always_comb begin
        sy_d = sy_q;
        sy_d.tog_s1 = ln_q.tog;
        sy_d.tog_s2 = sy_q.tog_s1;
        sy_d.tog_s3 = sy_q.tog_s2;
        sy_d.pulse = sy_q.tog_s2 ^ sy_q.tog_s3;
        if (sy_q.tog_s2 ^ sy_q.tog_s3) begin
            sy_d.regs = ln_q.active;
        end
        if (sys_rst) begin
            sy_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        sy_q <= sy_d;
    end

    assign active_regs = sy_q.regs;
    assign commit_pulse = sy_q.pulse;
endmodule

// *** rtl/icp_target.sv ***
`timescale 1ns/10ps
// Functional notes
// R1 - straps pick four-wire or two-wire port
// R2 - address 11000 plus two strap bits
// R3 - works at 100 kHz and 400 kHz
// R4 - target only, never drives clock
// R5 - two address bytes, high byte first
// R6 - data changes only while clock low
// R7 - start and stop detected while clock high
// R8 - eight bits MSB first, then acknowledge
// R9 - acknowledge low, not-acknowledge left high
// R10 - address byte ends with direction bit
// R11 - acknowledge own address, else stay idle
// R12 - write data auto-increments register address
// R13 - read data auto-increments from held address
// R14 - not-acknowledge on read releases data line
// R15 - controller stops after last write acknowledge
// R16 - repeated start accepted, partial bytes dropped
// R17 - not-acknowledge data after writing commit register
// R18 - reads after commit register return zero
// R19 - address-only write loads pointer
// R20 - combined read: address write, repeated start
// R21 - staged writes, commit bit copies all
// R22 - store write byte when acknowledging it
module icp_target (
    // link side
    icp_if.tgt link,
    // system side
    input wire logic clock,
    input wire logic sys_rst,
    // port select straps
    input wire logic port_strap_high,
    input wire logic port_strap_low,
    // status
    output logic spi_port_en,
    output logic [6:0] target_addr,
    // active registers
    output icp_pkg::icp_regs_t active_regs,
    output logic commit_pulse
);
    typedef struct packed {
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [1:0] strap;
        logic strap_done;
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        icp_pkg::icp_tst_t st;
        icp_pkg::icp_phase_t ph;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic rw;
        logic mnack;
        logic [15:0] ptr;
        logic past_commit;
        logic hold_low;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [7:0] wr_data;
    } icp_tgt_t;

    icp_tgt_t q;
    icp_tgt_t d;
    logic [1:0] rst_sync_q;
    logic link_rst;
    logic [7:0] rd_data;
    logic [6:0] own_addr;
    logic i2c_en;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    // reset release into the link domain
    always_ff @(posedge link.link_clk) begin
        rst_sync_q <= {rst_sync_q[0], sys_rst};
    end
    assign link_rst = rst_sync_q[1];

    icp_regbank u_bank (
        .link_clk (link.link_clk),
        .link_rst (link_rst),
        .wr_en (q.wr_en),
        .wr_addr (q.wr_addr),
        .wr_data (q.wr_data),
        .rd_addr (q.ptr),
        .rd_data (rd_data),
        .clock (clock),
        .sys_rst (sys_rst),
        .active_regs (active_regs),
        .commit_pulse (commit_pulse)
    );

    // strap code: low bits 00, 01, 10 for low/high, high/low, high/high
    assign own_addr = {icp_pkg::ADDR_UPPER, q.strap[1] & q.strap[0],
        q.strap[1] & ~q.strap[0]}; // see R2
    assign i2c_en = q.strap_done && (q.strap != icp_pkg::STRAP_FOUR_WIRE); // see R1

    // bus conditions seen on synchronised copies
    assign start_cond = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2; // see R7
    assign stop_cond = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2; // see R7
    assign scl_rise = q.scl_s2 & ~q.scl_s3;
    assign scl_fall = ~q.scl_s2 & q.scl_s3;

    // next read byte, first bit placed on the line at once
    function automatic icp_tgt_t load_byte(input icp_tgt_t s, input logic [7:0] rdat);
        logic [7:0] b;
        b = (s.past_commit || s.ptr == icp_pkg::COMMIT_ADDR) ?
            icp_pkg::READ_FILL : rdat; // see R18
        s.sh = b;
        s.hold_low = ~b[7]; // see R8
        s.bitcnt = '0;
        s.st = icp_pkg::T_TX;
        if (s.ptr == icp_pkg::COMMIT_ADDR) begin
            s.past_commit = 1'b1; // see R18
        end
        s.ptr = s.ptr + 16'h0001; // see R13
        return s;
    endfunction

    always_comb begin
        d = q;
        d.wr_en = 1'b0;
        d.strap_s1 = {port_strap_high, port_strap_low};
        d.strap_s2 = q.strap_s1;
        if (!q.strap_done) begin
            d.strap = q.strap_s2; // see R1
            d.strap_done = 1'b1;
        end
        // link clock oversamples both wires well above fast mode rate
        d.scl_s1 = link.scl; // see R3
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = link.sda;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;

        if (start_cond) begin
            // also a repeated start: any partial byte is dropped
            d.st = icp_pkg::T_RX; // see R16
            d.ph = icp_pkg::PH_DEV;
            d.bitcnt = '0;
            d.hold_low = 1'b0;
            d.past_commit = 1'b0;
        end else if (stop_cond) begin
            d.st = icp_pkg::T_IDLE; // see R16
            d.hold_low = 1'b0;
        end else if (scl_rise) begin
            if (q.st == icp_pkg::T_RX) begin
                d.sh = {q.sh[6:0], q.sda_s2}; // see R6
                d.bitcnt = q.bitcnt + 4'h1;
            end
            if (q.st == icp_pkg::T_RACK) begin
                d.mnack = q.sda_s2; // see R9
            end
        end else if (scl_fall) begin
            case (q.st)
                icp_pkg::T_RX: begin
                    if (q.bitcnt == icp_pkg::BITS_PER_BYTE) begin // see R8
                        d.bitcnt = '0;
                        d.st = icp_pkg::T_ACK;
                        d.hold_low = 1'b1; // see R9
                        case (q.ph)
                            icp_pkg::PH_DEV: begin
                                if (i2c_en && q.sh[7:1] == own_addr) begin // see R11
                                    d.rw = q.sh[0]; // see R10
                                    d.ph = q.sh[0] ? icp_pkg::PH_DATA : icp_pkg::PH_AHI;
                                end else begin
                                    d.st = icp_pkg::T_IDLE; // see R11
                                    d.hold_low = 1'b0;
                                end
                            end
                            icp_pkg::PH_AHI: begin
                                d.ptr[15:8] = q.sh; // see R5
                                d.ph = icp_pkg::PH_ALO;
                            end
                            icp_pkg::PH_ALO: begin
                                // pointer alone stays for a later read
                                d.ptr[7:0] = q.sh; // see R5 see R19 see R20
                                d.ph = icp_pkg::PH_DATA;
                            end
                            default: begin
                                if (q.past_commit) begin
                                    d.st = icp_pkg::T_IDLE; // see R17
                                    d.hold_low = 1'b0;
                                end else begin
                                    d.wr_en = 1'b1; // see R22
                                    d.wr_addr = q.ptr;
                                    d.wr_data = q.sh;
                                    d.ptr = q.ptr + 16'h0001; // see R12
                                    if (q.ptr == icp_pkg::COMMIT_ADDR) begin
                                        d.past_commit = 1'b1; // see R17
                                    end
                                end
                            end
                        endcase
                    end
                end
                icp_pkg::T_ACK: begin
                    d.hold_low = 1'b0;
                    if (q.rw) begin
                        d = load_byte(d, rd_data); // see R13
                    end else begin
                        d.st = icp_pkg::T_RX;
                    end
                end
                icp_pkg::T_TX: begin
                    if (q.bitcnt == icp_pkg::BITS_PER_BYTE - 4'h1) begin
                        d.st = icp_pkg::T_RACK;
                        d.hold_low = 1'b0;
                    end else begin
                        d.bitcnt = q.bitcnt + 4'h1;
                        d.sh = {q.sh[6:0], 1'b0};
                        d.hold_low = ~q.sh[6]; // see R6
                    end
                end
                icp_pkg::T_RACK: begin
                    if (q.mnack) begin
                        d.st = icp_pkg::T_IDLE; // see R14
                    end else begin
                        d = load_byte(d, rd_data);
                    end
                end
                default: begin
                end
            endcase
        end

        if (link_rst) begin
            d = '0;
            // straps keep shifting so the capture after release sees the pins
            d.strap_s1 = {port_strap_high, port_strap_low};
            d.strap_s2 = q.strap_s1; // see R1
            d.st = icp_pkg::T_IDLE;
            d.ph = icp_pkg::PH_DEV;
            d.scl_s1 = 1'b1;
            d.scl_s2 = 1'b1;
            d.scl_s3 = 1'b1;
            d.sda_s1 = 1'b1;
            d.sda_s2 = 1'b1;
            d.sda_s3 = 1'b1;
        end
    end

    always_ff @(posedge link.link_clk) begin
        q <= d;
    end

    // data line only pulled low; no clock output exists
    assign link.dev_sda_out = 1'b0; // see R4
    assign link.dev_sda_oe_n = ~q.hold_low;
    assign spi_port_en = q.strap_done && (q.strap == icp_pkg::STRAP_FOUR_WIRE);
    assign target_addr = own_addr;
endmodule

// *** rtl/icp_controller.sv ***
`timescale 1ns/10ps
module icp_controller (
    // system
    input wire logic clock,
    input wire logic sys_rst,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input icp_pkg::icp_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    input wire logic fast_mode,
    // response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    // bus
    icp_if.ctrl bus
);
    typedef struct packed {
        logic sda_s1;
        logic sda_s2;
        icp_pkg::icp_hst_t st;
        logic [7:0] div;
        logic [1:0] qtr;
        logic [3:0] bitn;
        logic [8:0] tx;
        logic [8:0] rx;
        logic scl;
        logic sda;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_nack;
    } icp_host_t;

    icp_host_t q;
    icp_host_t d;
    logic [7:0] reload;

    assign reload = fast_mode ? 8'(icp_pkg::QTR_FAST - 1) : 8'(icp_pkg::QTR_STD - 1);
    assign cmd_ready = (q.st == icp_pkg::H_IDLE);

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.sda_s1 = bus.sda;
        d.sda_s2 = q.sda_s1;
        if (q.st == icp_pkg::H_IDLE) begin
            if (cmd_valid) begin
                d.div = reload;
                d.qtr = '0;
                d.bitn = '0;
                case (cmd_op)
                    icp_pkg::OP_START: d.st = icp_pkg::H_START;
                    icp_pkg::OP_STOP: begin
                        // bus already free: nothing to send
                        if (q.scl) begin
                            d.rsp_valid = 1'b1;
                        end else begin
                            d.st = icp_pkg::H_STOP;
                        end
                    end
                    icp_pkg::OP_WRITE: begin
                        d.st = icp_pkg::H_BYTE; // see R5 see R10
                        d.tx = {cmd_data, 1'b1};
                    end
                    default: begin
                        // last read byte carries the not-acknowledge
                        d.st = icp_pkg::H_BYTE; // see R14
                        d.tx = {8'hFF, cmd_nack};
                    end
                endcase
            end
        end else if (q.div != 8'h00) begin
            d.div = q.div - 8'h01;
        end else begin
            d.div = reload;
            d.qtr = q.qtr + 2'h1;
            case (q.st)
                icp_pkg::H_START: begin
                    case (q.qtr)
                        2'h0: d.sda = 1'b1;
                        2'h1: d.scl = 1'b1;
                        2'h2: d.sda = 1'b0; // see R7
                        default: begin
                            d.scl = 1'b0;
                            d.st = icp_pkg::H_IDLE;
                            d.rsp_valid = 1'b1;
                        end
                    endcase
                end
                icp_pkg::H_BYTE: begin
                    case (q.qtr)
                        2'h0: d.sda = q.tx[8]; // see R6 see R8
                        2'h1: d.scl = 1'b1;
                        2'h2: d.rx = {q.rx[7:0], q.sda_s2}; // see R9
                        default: begin
                            d.scl = 1'b0;
                            d.tx = {q.tx[7:0], 1'b1};
                            d.bitn = q.bitn + 4'h1;
                            if (q.bitn == icp_pkg::BITS_PER_BYTE) begin
                                d.st = icp_pkg::H_IDLE;
                                d.rsp_valid = 1'b1;
                                d.rsp_data = q.rx[8:1];
                                d.rsp_nack = q.rx[0];
                            end
                        end
                    endcase
                end
                icp_pkg::H_STOP: begin
                    case (q.qtr)
                        2'h0: d.sda = 1'b0;
                        2'h1: d.scl = 1'b1;
                        2'h2: d.sda = 1'b1; // see R7 see R15
                        default: begin
                            d.st = icp_pkg::H_IDLE;
                            d.rsp_valid = 1'b1;
                        end
                    endcase
                end
                default: d.st = icp_pkg::H_IDLE;
            endcase
        end
        if (sys_rst) begin
            d = '0;
            d.st = icp_pkg::H_IDLE;
            d.scl = 1'b1;
            d.sda = 1'b1;
            d.sda_s1 = 1'b1;
            d.sda_s2 = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign bus.scl_out = 1'b0;
    assign bus.scl_oe_n = q.scl;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe_n = q.sda;
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign rsp_nack = q.rsp_nack;
endmodule

// *** tb/icp_monitor.sv ***
`timescale 1ns/10ps
module icp_monitor (
    // system domain
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_oe_n,
    input wire logic host_sda_oe_n,
    // link domain
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe_n
);
    a_scl_high_len: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(scl_oe_n) |-> scl_oe_n [*8]) else $error("scl high too short");
    a_scl_low_len: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(scl_oe_n) |-> !scl_oe_n [*8]) else $error("scl low too short");
    // start and stop are the only host moves while scl is high, a quarter in
    a_host_sda_setup: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(host_sda_oe_n) && scl_oe_n |-> $past(scl_oe_n, 6))
        else $error("host data moved near scl rise");
    a_start_scl_low: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(host_sda_oe_n) && scl_oe_n |-> scl_oe_n [*5] ##[1:30] !scl_oe_n)
        else $error("start not followed by scl low");
    a_stop_scl_high: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(host_sda_oe_n) && scl_oe_n |-> scl_oe_n [*8])
        else $error("scl dropped after stop");
    a_dev_sda_stable: assert property (@(posedge link_clk) disable iff (sys_rst)
        scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("target data moved scl high");
    a_dev_change_low: assert property (@(posedge link_clk) disable iff (sys_rst)
        $changed(dev_sda_oe_n) |-> !scl && !$past(scl, 2))
        else $error("target data moved near scl edge");
    a_dev_drive_len: assert property (@(posedge link_clk) disable iff (sys_rst)
        $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8]) else $error("target drive too short");
    c_start: cover property (@(posedge clock) $fell(host_sda_oe_n) && scl_oe_n);
    c_dev_ack: cover property (@(posedge link_clk) $fell(dev_sda_oe_n));
    c_stop: cover property (@(posedge link_clk) scl && $rose(sda));
endmodule

// *** tb/i2c_register_control_port_tb_top.sv ***
`timescale 1ns/10ps
module i2c_register_control_port_tb_top;
    localparam logic [7:0] DEV_W = {icp_pkg::ADDR_UPPER, 2'h1, 1'b0};
    localparam logic [7:0] DEV_R = {icp_pkg::ADDR_UPPER, 2'h1, 1'b1};
    localparam int LIMIT = 40000;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic strap_hi = 1'b1;
    logic strap_lo = 1'b0;
    logic cmd_valid = 1'b0;
    icp_pkg::icp_op_t cmd_op = icp_pkg::OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nack = 1'b0;
    logic fast_mode = 1'b1;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_nack;
    logic spi_port_en;
    logic commit_pulse;
    logic [7:0] rsp_data;
    logic [6:0] target_addr;
    icp_pkg::icp_regs_t active_regs;
    logic [8:0] wire_bits = 9'h000;
    logic [7:0] stage [8];
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_commit = 0;

    always #50 clock = ~clock;
    always #24 link_clk = ~link_clk;

    icp_if link_bus (.link_clk(link_clk));
    icp_target u_icp_target (.link(link_bus.tgt), .clock(clock), .sys_rst(sys_rst),
        .port_strap_high(strap_hi), .port_strap_low(strap_lo), .spi_port_en(spi_port_en),
        .target_addr(target_addr), .active_regs(active_regs), .commit_pulse(commit_pulse));
    icp_controller u_icp_controller (.clock(clock), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .fast_mode(fast_mode), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus(link_bus.ctrl));
    icp_monitor u_icp_monitor (.clock(clock), .sys_rst(sys_rst),
        .scl_oe_n(link_bus.scl_oe_n), .host_sda_oe_n(link_bus.host_sda_oe_n),
        .link_clk(link_clk), .scl(link_bus.scl), .sda(link_bus.sda),
        .dev_sda_oe_n(link_bus.dev_sda_oe_n));

    // last nine bits seen on the wire
    always @(posedge link_bus.scl) wire_bits <= {wire_bits[7:0], link_bus.sda};

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (commit_pulse === 1'b1) n_commit <= n_commit + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic rst(input logic h, input logic l);
        strap_hi <= h;
        strap_lo <= l;
        sys_rst <= 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clock);
    endtask

    // one command, held until taken, then wait for its answer
    task automatic op(input icp_pkg::icp_op_t o, input logic [7:0] d, input logic nk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_data <= d;
        cmd_nack <= nk;
        @(posedge clock);
        while (cmd_ready !== 1'b1) @(posedge clock);
        cmd_valid <= 1'b0;
        for (int i = 0; i < 1000 && rsp_valid !== 1'b1; i++) @(posedge clock);
    endtask

    task automatic wb(input logic [7:0] d, input logic nk);
        op(icp_pkg::OP_WRITE, d, 1'b0);
        chk(rsp_nack, nk);
        chk(wire_bits, {d, nk});
    endtask

    task automatic rb(input logic nk, input logic [7:0] e);
        op(icp_pkg::OP_READ, 8'h00, nk);
        chk(rsp_data, e);
        chk(wire_bits, {e, nk});
    endtask

    task automatic head(input logic [15:0] a);
        op(icp_pkg::OP_START, 8'h00, 1'b0);
        wb(DEV_W, 1'b0);
        wb(a[15:8], 1'b0);
        wb(a[7:0], 1'b0);
    endtask

    task automatic t_straps();
        for (int p = 0; p < 4; p++) begin
            rst(p[1], p[0]);
            chk(spi_port_en, p == 0);
            if (p != 0) chk(target_addr, {icp_pkg::ADDR_UPPER, 2'(p - 1)});
            op(icp_pkg::OP_START, 8'h00, 1'b0);
            wb(DEV_W, p != 2);
            op(icp_pkg::OP_STOP, 8'h00, 1'b0);
            chk({link_bus.scl, link_bus.sda}, 2'h3);
        end
        rst(1'b1, 1'b0);
    endtask

    task automatic t_write();
        fast_mode <= 1'b0;
        head(16'h0000);
        for (int i = 0; i < 8; i++) begin
            stage[i] = 8'(8'ha5 + i * 19);
            wb(stage[i], 1'b0);
        end
        wb(8'h77, 1'b0);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
        chk(active_regs, 64'h0000_0000_0000_0000);
        fast_mode <= 1'b1;
    endtask

    task automatic t_read();
        head(16'h0002);
        op(icp_pkg::OP_START, 8'h00, 1'b0);
        wb(DEV_R, 1'b0);
        for (int i = 2; i < 9; i++) rb(i == 8, i < 8 ? stage[i] : 8'h00);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
        chk({link_bus.scl, link_bus.sda}, 2'h3);
    endtask

    task automatic t_pointer();
        head(16'h0005);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
        op(icp_pkg::OP_START, 8'h00, 1'b0);
        wb(DEV_R, 1'b0);
        rb(1'b0, stage[5]);
        rb(1'b1, stage[6]);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
    endtask

    task automatic t_commit();
        logic [63:0] e;
        for (int i = 0; i < 8; i++) e[8*i +: 8] = stage[i];
        head(icp_pkg::COMMIT_ADDR);
        wb(8'h01, 1'b0);
        wb(8'h5a, 1'b1);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
        chk(n_commit, 1);
        chk(active_regs, e);
        head(icp_pkg::COMMIT_ADDR);
        op(icp_pkg::OP_START, 8'h00, 1'b0);
        wb(DEV_R, 1'b0);
        rb(1'b0, 8'h00);
        rb(1'b1, 8'h00);
        op(icp_pkg::OP_STOP, 8'h00, 1'b0);
    endtask

    initial begin
        t_straps();
        t_write();
        t_read();
        t_pointer();
        t_commit();
        close_out();
    end
endmodule
